/* ieee_stat_pkg.sv */
// package: constants and types for the status reporting block
package ieee_stat_pkg;
  // standard event status bit positions
  localparam int ESR_PON_BIT = 7;
  localparam int ESR_CME_BIT = 5;
  localparam int ESR_EXE_BIT = 4;
  localparam int ESR_ALM_BIT = 3;
  localparam int ESR_OPC_BIT = 0;
  // implemented event bits, unused ones read zero
  localparam logic [7:0] ESR_USED_MASK = 8'hb9;
  // event register value after power-up (power-on flag set)
  localparam logic [7:0] ESR_RESET_VAL = 8'h80;
  // enable masks after power-up
  localparam logic [7:0] ESE_RESET_VAL = 8'h00;
  localparam logic [7:0] SRE_RESET_VAL = 8'h00;
  // status byte bit positions
  localparam int STB_TMO_BIT = 0;
  localparam int STB_AUX_BUS_EXEC_ERROR_BIT = 1;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  // status byte bits able to raise a service request
  localparam logic [7:0] STB_SRC_MASK = 8'h33;

  // multi-line bus messages delivered by the handshake logic
  typedef enum logic [3:0] {
    MSG_DCL, MSG_SPE, MSG_SPD, MSG_PPU, MSG_LLO, MSG_UNL, MSG_UNT,
    MSG_SDC, MSG_PPC, MSG_GTL, MSG_GET, MSG_TCT, MSG_MLA, MSG_MTA,
    MSG_IFC
  } ieee_busmsg_e;

  // remote/local states
  typedef enum logic [1:0] {
    RS_LOCAL, RS_REMOTE, RS_LOCKOUT
  } ieee_rstate_e;

  // whole state of the block
  typedef struct packed {
    logic         renMeta;     // first sync stage of remote enable
    logic         renSync;     // second sync stage
    logic [7:0]   std_event_status;         // standard event status
    logic [7:0]   std_event_enable;         // standard event enable
    logic [7:0]   sre;         // service request enable
    logic         auxErr;      // aux bus execution error latch
    logic         auxTmo;      // aux bus time-out latch
    logic         mssPrev;     // master summary, previous cycle
    logic         rqs;         // request-service flag
    ieee_rstate_e rstate;      // remote/local state
    logic         llo;         // lockout requested by controller
    logic         talker;      // addressed as talker
    logic         listener;    // addressed as listener
    logic         spMode;      // serial poll mode
    logic [7:0]   resp;        // response byte
    logic         respValid;   // response strobe
    logic         flush;       // flush buffers strobe
    logic         mss;         // registered master summary
  } ieee_state_s;
endpackage

/* ieee_status_reporting.sv */
// status reporting and remote/local state logic of an instrument
`timescale 1ns/10ps

module ieee_status_reporting (
  input  wire logic                        clk,          // 20 MHz clock
  input  wire logic                        sys_rst,      // async reset
  input  wire logic                        renPin,       // remote enable
  input  wire logic                        busMsgValid,  // message strobe
  input  wire ieee_stat_pkg::ieee_busmsg_e busMsgCode,   // message code
  input  wire logic                        spollRead,    // poll byte taken
  input  wire logic                        eseWrite,     // event mask set
  input  wire logic                        sreWrite,     // service mask set
  input  wire logic [7:0]                  cmdData,      // mask value
  input  wire logic                        eseQuery,     // event mask query
  input  wire logic                        sreQuery,     // service mask qry
  input  wire logic                        esrQuery,     // event reg query
  input  wire logic                        stbQuery,     // status byte qry
  input  wire logic                        clsCmd,       // clear status
  input  wire logic                        rstCmd,       // reset command
  input  wire logic                        cmdErrorEvt,  // parse error
  input  wire logic                        execErrorEvt, // exec failure
  input  wire logic                        alarmEvent,   // alarm event
  input  wire logic                        opCompleteEvt,// op complete
  input  wire logic                        auxBusExecErrorEvt, // aux err
  input  wire logic                        auxBusTimeoutEvt,   // aux tmo
  input  wire logic                        outQueueNotEmpty,   // queue data
  input  wire logic                        localKeyPress,// local key
  input  wire logic                        errorActive,  // error showing
  output logic [7:0]                       respData,     // response byte
  output logic                             respValid,    // response strobe
  output logic                             srqOut,       // service request
  output logic                             flushBuffers, // flush strobe
  output ieee_stat_pkg::ieee_rstate_e      remoteState,  // remote state
  output logic                             talkerActive, // addressed talker
  output logic                             listenerActive,// addr listener
  output logic                             serialPollMode,// poll mode
  output logic                             panelKeysEnable,// panel keys
  output logic                             localKeyEnable  // local key
);
  import ieee_stat_pkg::*;

  ieee_state_s stReg;   // registered state
  ieee_state_s stNext;  // next state

  logic       devClear;     // device clear message applies
  logic [7:0] evVec;        // events arriving this cycle
  logic [7:0] stbSrc;       // status byte without bit 6
  logic       mssNow;       // master summary of current state
  logic       esrClear;     // event register cleared this cycle
  logic       msgIs;        // message strobe gate

  // status byte built from current sources
  always_comb begin
    stbSrc = 8'h00;
    stbSrc[STB_ESB_BIT] = |(stReg.std_event_status & stReg.std_event_enable);
    stbSrc[STB_MAV_BIT] = outQueueNotEmpty;
    stbSrc[STB_AUX_BUS_EXEC_ERROR_BIT] = stReg.auxErr;
    stbSrc[STB_TMO_BIT] = stReg.auxTmo;
    // bits fall only as their sources fall
    mssNow = |(stbSrc & stReg.sre & STB_SRC_MASK);
  end

  // next-state logic
  always_comb begin
    stNext = stReg;
    msgIs = busMsgValid;
    // one-cycle strobes default low
    stNext.respValid = 1'b0;
    stNext.flush = 1'b0;
    // remote enable pin synchroniser
    stNext.renMeta = renPin;
    stNext.renSync = stReg.renMeta;

    // device clear: universal, or selected while addressed
    devClear = msgIs && ((busMsgCode == MSG_DCL) ||
               (busMsgCode == MSG_SDC && stReg.listener));

    // incoming events for the event register
    evVec = 8'h00;
    evVec[ESR_CME_BIT] = cmdErrorEvt;
    evVec[ESR_EXE_BIT] = execErrorEvt;
    evVec[ESR_ALM_BIT] = alarmEvent;
    evVec[ESR_OPC_BIT] = opCompleteEvt;

    // read, clear-status, device clear and reset empty the register
    esrClear = esrQuery || clsCmd || devClear || rstCmd;
    if (esrClear) begin
      stNext.std_event_status = evVec & ESR_USED_MASK;
    end else begin
      stNext.std_event_status = (stReg.std_event_status | evVec) & ESR_USED_MASK;
    end

    // aux bus latches, cleared with the status byte
    if (clsCmd || devClear || rstCmd) begin
      stNext.auxErr = auxBusExecErrorEvt;
      stNext.auxTmo = auxBusTimeoutEvt;
    end else begin
      stNext.auxErr = stReg.auxErr | auxBusExecErrorEvt;
      stNext.auxTmo = stReg.auxTmo | auxBusTimeoutEvt;
    end

    // event enable mask
    if (rstCmd) begin
      stNext.std_event_enable = ESE_RESET_VAL;
    end else if (eseWrite) begin
      stNext.std_event_enable = cmdData & ESR_USED_MASK;
    end

    // service request enable mask
    if (rstCmd) begin
      stNext.sre = SRE_RESET_VAL;
    end else if (sreWrite) begin
      stNext.sre = cmdData & STB_SRC_MASK;
    end

    // master summary and request-service flag
    stNext.mss = mssNow;
    stNext.mssPrev = mssNow;
    if (mssNow && !stReg.mssPrev) begin
      stNext.rqs = 1'b1;
    end else if (!mssNow || spollRead || clsCmd ||
                 devClear || rstCmd) begin
      stNext.rqs = 1'b0;
    end

    // register readouts, one at a time
    if (spollRead) begin
      stNext.resp = stbSrc;
      stNext.resp[STB_MSS_BIT] = stReg.rqs;
      stNext.respValid = 1'b1;
    end else if (stbQuery) begin
      stNext.resp = stbSrc;
      stNext.resp[STB_MSS_BIT] = mssNow;
      stNext.respValid = 1'b1;
    end else if (esrQuery) begin
      stNext.resp = stReg.std_event_status;
      stNext.respValid = 1'b1;
    end else if (eseQuery) begin
      stNext.resp = stReg.std_event_enable;
      stNext.respValid = 1'b1;
    end else if (sreQuery) begin
      stNext.resp = stReg.sre;
      stNext.respValid = 1'b1;
    end

    // addressing and poll mode from bus messages
    if (msgIs) begin
      case (busMsgCode)
        MSG_MLA: stNext.listener = 1'b1;
        MSG_MTA: stNext.talker = 1'b1;
        MSG_UNL: stNext.listener = 1'b0;
        MSG_UNT: stNext.talker = 1'b0;
        MSG_SPE: stNext.spMode = 1'b1;
        MSG_SPD: stNext.spMode = 1'b0;
        MSG_IFC: begin
          stNext.talker = 1'b0;
          stNext.listener = 1'b0;
          stNext.spMode = 1'b0;
        end
        default: begin
          // poll config, trigger, transfer: ignored
          stNext.spMode = stReg.spMode;
        end
      endcase
    end
    if (devClear || rstCmd) begin
      stNext.talker = 1'b0;
      stNext.listener = 1'b0;
      stNext.flush = 1'b1;
    end

    // remote/local state machine
    if (!stReg.renSync) begin
      stNext.rstate = RS_LOCAL;
      stNext.llo = 1'b0;
    end else if (devClear) begin
      stNext.rstate = RS_LOCAL;
      stNext.llo = 1'b0;
    end else begin
      case (stReg.rstate)
        RS_LOCAL: begin
          if (msgIs && busMsgCode == MSG_LLO) begin
            stNext.llo = 1'b1;
          end else if (msgIs && busMsgCode == MSG_MLA) begin
            stNext.rstate = stReg.llo ? RS_LOCKOUT : RS_REMOTE;
          end
        end
        RS_REMOTE: begin
          if (msgIs && busMsgCode == MSG_LLO) begin
            stNext.llo = 1'b1;
            stNext.rstate = RS_LOCKOUT;
          end else if (msgIs && busMsgCode == MSG_GTL &&
                       stReg.listener) begin
            stNext.rstate = RS_LOCAL;
          end else if (localKeyPress) begin
            stNext.rstate = RS_LOCAL;
          end
        end
        RS_LOCKOUT: begin
          // local key is ignored here
          if (msgIs && busMsgCode == MSG_GTL && stReg.listener) begin
            stNext.rstate = RS_LOCAL;
          end
        end
        default: stNext.rstate = RS_LOCAL;
      endcase
    end
  end

  // state register; power-up values
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stReg <= '0;
      stReg.std_event_status <= ESR_RESET_VAL;
      stReg.std_event_enable <= ESE_RESET_VAL;
      stReg.sre <= SRE_RESET_VAL;
      stReg.rstate <= RS_LOCAL;
    end else begin
      stReg <= stNext;
    end
  end

  // outputs from the state register; localKeyEnable also takes errorActive directly
  assign respData = stReg.resp;
  assign respValid = stReg.respValid;
  assign srqOut = stReg.rqs;
  assign flushBuffers = stReg.flush;
  assign remoteState = stReg.rstate;
  assign talkerActive = stReg.talker;
  assign listenerActive = stReg.listener;
  assign serialPollMode = stReg.spMode;
  assign panelKeysEnable = (stReg.rstate == RS_LOCAL);
  assign localKeyEnable = (stReg.rstate != RS_LOCKOUT) ||
                          errorActive;

  // checks
  // a failed execution is recorded in the event register
  a_exe_sets_bit: assert property (
    @(posedge clk) disable iff (sys_rst)
    execErrorEvt |=> stReg.std_event_status[ESR_EXE_BIT])
    else $error("execution error not recorded");
  // a read with no new event leaves the register empty
  a_esr_read_clears: assert property (
    @(posedge clk) disable iff (sys_rst)
    (esrQuery && evVec == 8'h00) |=> stReg.std_event_status == 8'h00)
    else $error("event register not cleared by read");
  // unused event and mask positions stay zero
  a_unused_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    (stReg.std_event_enable & ~ESR_USED_MASK) == 8'h00 &&
    (stReg.std_event_status & ~ESR_USED_MASK) == 8'h00)
    else $error("unused event bits set");
  // request flag follows each summary rise
  a_rqs_on_rise: assert property (
    @(posedge clk) disable iff (sys_rst)
    (mssNow && !stReg.mssPrev) |=> srqOut)
    else $error("request flag missed summary rise");
  // request flag falls with the summary
  a_rqs_drops: assert property (
    @(posedge clk) disable iff (sys_rst)
    (!mssNow) |=> !srqOut)
    else $error("request flag held without summary");
  // a service request only stands with the master summary
  a_srq_has_mss: assert property (
    @(posedge clk) disable iff (sys_rst)
    srqOut |-> stReg.mss)
    else $error("service request without summary");
  // status query shows the master summary in bit 6
  a_stb_query: assert property (
    @(posedge clk) disable iff (sys_rst)
    (stbQuery && !spollRead) |=>
    respValid && respData[STB_MSS_BIT] == $past(mssNow))
    else $error("status query bit 6 wrong");
  // serial poll shows the request flag and clears it
  a_poll_clears: assert property (
    @(posedge clk) disable iff (sys_rst)
    (spollRead && !(mssNow && !stReg.mssPrev)) |=>
    respData[STB_MSS_BIT] == $past(stReg.rqs) && !srqOut)
    else $error("serial poll did not clear request flag");
  // event mask write keeps only implemented positions
  a_ese_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    (eseWrite && !rstCmd) |=>
    stReg.std_event_enable == ($past(cmdData) & ESR_USED_MASK))
    else $error("event mask write lost");
  // service mask write keeps only request sources
  a_sre_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    (sreWrite && !rstCmd) |=>
    stReg.sre == ($past(cmdData) & STB_SRC_MASK))
    else $error("service mask write lost");
  // clear-status empties events and aux latches
  a_cls_clears: assert property (
    @(posedge clk) disable iff (sys_rst)
    (clsCmd && evVec == 8'h00 && !auxBusExecErrorEvt &&
     !auxBusTimeoutEvt) |=>
    stReg.std_event_status == 8'h00 && !stReg.auxErr && !stReg.auxTmo)
    else $error("clear status left bits set");
  // device clear returns to local, unaddressed, with a flush
  a_dcl_local: assert property (
    @(posedge clk) disable iff (sys_rst)
    devClear |=> remoteState == RS_LOCAL && flushBuffers &&
    !listenerActive)
    else $error("device clear did not return to local");
  // reset keeps the remote state and clears the event mask
  a_rst_keeps: assert property (
    @(posedge clk) disable iff (sys_rst)
    (rstCmd && !busMsgValid && stReg.renSync && !localKeyPress) |=>
    remoteState == $past(stReg.rstate) && stReg.std_event_enable == 8'h00)
    else $error("reset altered remote state or kept mask");
  // reset flushes and drops addressing
  a_rst_flush: assert property (
    @(posedge clk) disable iff (sys_rst)
    rstCmd |=> flushBuffers && !talkerActive && !listenerActive)
    else $error("reset did not flush or unaddress");
  // interface clear drops addressing, not the remote state
  a_ifc_keeps: assert property (
    @(posedge clk) disable iff (sys_rst)
    (busMsgValid && busMsgCode == MSG_IFC && stReg.renSync &&
     !localKeyPress) |=>
    !talkerActive && !listenerActive &&
    remoteState == $past(stReg.rstate))
    else $error("interface clear changed more than addressing");
  // lockout leaves the local key live only on error
  a_lockout_keys: assert property (
    @(posedge clk) disable iff (sys_rst)
    (remoteState == RS_LOCKOUT) |->
    !panelKeysEnable && (localKeyEnable == errorActive))
    else $error("keys live in lockout");
endmodule

/* ieee_ctl_model.sv */
// controller model: remote enable, bus messages and serial poll
`timescale 1ns/10ps
module ieee_ctl_model (
  input  wire logic                   clk,         // bus clock
  input  wire logic [7:0]             respData,    // byte from device
  output ieee_stat_pkg::ieee_busmsg_e busMsgCode,  // message code
  output logic                        busMsgValid, // message strobe
  output logic                        renPin,      // remote enable line
  output logic                        spollRead    // poll byte taken
);
  import ieee_stat_pkg::*;

  // lines idle at time zero
  initial begin
    renPin      = 1'b0;
    busMsgValid = 1'b0;
    busMsgCode  = MSG_UNL;
    spollRead   = 1'b0;
  end

  // remote enable change, then let the two-flop sync settle
  task automatic setRen(input logic v);
    @(posedge clk);
    renPin <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // one message for one cycle; the released code is scrambled
  task automatic send(input ieee_busmsg_e c);
    @(posedge clk);
    busMsgValid <= 1'b1;
    busMsgCode  <= c;
    @(posedge clk);
    busMsgValid <= 1'b0;
    busMsgCode  <= ieee_busmsg_e'(~c);
    #1;
  endtask

  // serial poll: byte is registered at the edge that takes the strobe, read one cycle later
  task automatic poll(output logic [7:0] b);
    @(posedge clk);
    spollRead <= 1'b1;
    @(posedge clk);
    spollRead <= 1'b0;
    @(posedge clk);
    #1;
    b = respData;
  endtask
endmodule

/* tb_top.sv */
// self-checking bench for the status reporting block
`timescale 1ns/10ps
module tb_top;
  import ieee_stat_pkg::*;
  // strobe positions inside st
  localparam int ESEW = 0, SREW = 1, ESEQ = 2, SREQ = 3, ESRQ = 4;
  localparam int STBQ = 5, CLS = 6, RST = 7, LKEY = 14;
  logic         clk = 1'b0;     // 20 MHz clock
  logic         sys_rst = 1'b1; // power-up reset
  logic [14:0]  st = '0;        // command, event and key strobes
  logic [7:0]   cmdData = '0;   // mask value
  logic         outQ = 1'b0;    // output queue holds data
  logic         errAct = 1'b0;  // error showing
  logic [7:0]   respData;       // response byte
  logic         respValid, srqOut, flushBuffers;
  logic         talkerActive, listenerActive, serialPollMode;
  logic         panelKeysEnable, localKeyEnable;
  logic         renPin, busMsgValid, spollRead;
  ieee_busmsg_e busMsgCode;     // message from the controller
  ieee_rstate_e remoteState;    // remote/local state
  int           n_fail = 0;     // mismatches
  int           check_count = 0;// comparisons
  logic [31:0]  seed = 32'hcd5ffaca; // random state
  ieee_busmsg_e ign [4] = '{MSG_PPU, MSG_PPC, MSG_GET, MSG_TCT};

  // clock
  always #25 clk = ~clk;

  ieee_status_reporting uut (
    .clk(clk), .sys_rst(sys_rst), .renPin(renPin),
    .busMsgValid(busMsgValid), .busMsgCode(busMsgCode),
    .spollRead(spollRead), .eseWrite(st[0]), .sreWrite(st[1]),
    .cmdData(cmdData), .eseQuery(st[2]), .sreQuery(st[3]),
    .esrQuery(st[4]), .stbQuery(st[5]), .clsCmd(st[6]), .rstCmd(st[7]),
    .cmdErrorEvt(st[8]), .execErrorEvt(st[9]), .alarmEvent(st[10]),
    .opCompleteEvt(st[11]), .auxBusExecErrorEvt(st[12]),
    .auxBusTimeoutEvt(st[13]), .outQueueNotEmpty(outQ),
    .localKeyPress(st[14]), .errorActive(errAct), .respData(respData),
    .respValid(respValid), .srqOut(srqOut), .flushBuffers(flushBuffers),
    .remoteState(remoteState), .talkerActive(talkerActive),
    .listenerActive(listenerActive), .serialPollMode(serialPollMode),
    .panelKeysEnable(panelKeysEnable), .localKeyEnable(localKeyEnable)
  );

  // far-side controller
  ieee_ctl_model ctl (
    .clk(clk), .respData(respData), .busMsgCode(busMsgCode),
    .busMsgValid(busMsgValid), .renPin(renPin), .spollRead(spollRead)
  );

  // next random word
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // event register after pulses cme, exe, alm, opc in r[3:0]
  function automatic logic [7:0] esrOf(input logic [6:0] r);
    return {2'b00, r[0], r[1], r[2], 2'b00, r[3]};
  endfunction

  // status byte with the master summary in bit 6
  function automatic logic [7:0] stbVal(input logic [7:0] std_event_status, std_event_enable,
                                        sre, input logic mav,
                                        input logic [1:0] aux);
    logic [7:0] b;
    b = {2'b00, |(std_event_status & std_event_enable), mav, 2'b00, aux};
    b[6] = |(b & sre);
    return b;
  endfunction

  // byte compare
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // flag compare
  task automatic chkBit(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  // remote state compare
  task automatic chkSt(input ieee_rstate_e e);
    chk8(8'(remoteState), 8'(e));
  endtask

  // strobe any set of inputs for one cycle, wait for the answer edge
  task automatic pulse(input logic [14:0] v, input logic [7:0] d);
    @(posedge clk);
    st      <= v;
    cmdData <= d;
    @(posedge clk);
    st <= '0;
    #1;
  endtask

  // one strobe
  task automatic q(input int i, input logic [7:0] d);
    pulse(15'(1) << i, d);
  endtask

  // query and compare the answer byte
  task automatic ask(input int i, input logic [7:0] e);
    q(i, 8'h00);
    chkBit(respValid, 1'b1);
    chk8(respData, e);
  endtask

  // verdict and end of run
  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  // main sequence
  initial begin
    logic [7:0] std_event_enable, sre, std_event_status, b, b2;
    logic [6:0] r;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    ask(ESRQ, 8'h80);
    ask(ESRQ, 8'h00);
    ask(ESEQ, 8'h00);
    ask(SREQ, 8'h00);
    ask(STBQ, 8'h00);
    chkSt(RS_LOCAL);
    // random masks, events and queue level
    for (int k = 0; k < 24; k++) begin
      seed = lfsr(seed);
      {r, sre, std_event_enable} = seed[22:0];
      q(RST, 8'h00);
      q(ESEW, std_event_enable);
      q(SREW, sre);
      ask(ESEQ, std_event_enable & ESR_USED_MASK);
      ask(SREQ, sre & STB_SRC_MASK);
      outQ <= r[6];
      pulse({1'b0, r[5:0], 8'h00}, 8'h00);
      std_event_status = esrOf(r);
      b = stbVal(std_event_status, std_event_enable, sre, r[6], {r[4], r[5]});
      ask(STBQ, b);
      chkBit(srqOut, b[6]);
      ctl.poll(b2);
      chk8(b2, b);
      chkBit(srqOut, 1'b0);
      ask(STBQ, b);
      ask(ESRQ, std_event_status);
      ask(ESRQ, 8'h00);
      q(CLS, 8'h00);
      ask(STBQ, stbVal(8'h00, std_event_enable, sre, r[6], 2'b00));
      outQ <= 1'b0;
      ask(STBQ, 8'h00);
    end
    // remote, lockout and clears
    ctl.setRen(1'b1);
    ctl.send(MSG_MLA);
    chkSt(RS_REMOTE);
    chkBit(panelKeysEnable, 1'b0);
    chkBit(localKeyEnable, 1'b1);
    foreach (ign[i]) begin
      ctl.send(ign[i]);
      chkSt(RS_REMOTE);
    end
    ctl.send(MSG_SPE);
    chkBit(serialPollMode, 1'b1);
    ctl.send(MSG_SPD);
    chkBit(serialPollMode, 1'b0);
    ctl.send(MSG_MTA);
    chkBit(talkerActive, 1'b1);
    ctl.send(MSG_UNT);
    chkBit(talkerActive, 1'b0);
    ctl.send(MSG_LLO);
    chkSt(RS_LOCKOUT);
    chkBit(localKeyEnable, 1'b0);
    errAct <= 1'b1;
    @(posedge clk);
    #1;
    chkBit(localKeyEnable, 1'b1);
    errAct <= 1'b0;
    ctl.send(MSG_IFC);
    chkBit(listenerActive, 1'b0);
    chkSt(RS_LOCKOUT);
    ctl.send(MSG_MLA);
    q(RST, 8'h00);
    chkBit(flushBuffers, 1'b1);
    chkSt(RS_LOCKOUT);
    ctl.send(MSG_MLA);
    ctl.send(MSG_GTL);
    chkSt(RS_LOCAL);
    ctl.send(MSG_MLA);
    chkSt(RS_LOCKOUT);
    ctl.send(MSG_MLA);
    ctl.send(MSG_DCL);
    chkBit(flushBuffers, 1'b1);
    chkSt(RS_LOCAL);
    ctl.send(MSG_MLA);
    chkSt(RS_REMOTE);
    ctl.send(MSG_SDC);
    chkBit(flushBuffers, 1'b1);
    chkSt(RS_LOCAL);
    ctl.send(MSG_MLA);
    q(LKEY, 8'h00);
    chkSt(RS_LOCAL);
    ctl.send(MSG_UNL);
    chkBit(listenerActive, 1'b0);
    ctl.send(MSG_MLA);
    ctl.send(MSG_GTL);
    chkSt(RS_LOCAL);
    ctl.send(MSG_MLA);
    ctl.setRen(1'b0);
    chkSt(RS_LOCAL);
    end_of_test();
  end
endmodule
